// ==== atb_trim_bank.sv ====
// analog trim register bank with AHB-Lite slave
//
// The implementer's own choice: the AHB-Lite register port.
`include "atb_regs.svh"

module atb_trim_bank
    import atb_pkg::*;
(
    // clock and resets
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        pwr_on_rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [15:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // analog trim codes
    output atb_trim_s        trim_out,
    output logic             sleep_bg_locked
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    wire logic        ap_take  = hsel & htrans[1] & hready;
    wire logic [13:0] word_idx = haddr[15:2];
    wire logic [13:0] rel_blk  = word_idx - `ATB_BASE_BLOCK;
    wire logic [13:0] rel_nbk  = word_idx - `ATB_BASE_NONBLK;
    wire logic        hit_blk  = (rel_blk >= `ATB_OFS_TRIM0)
                               & (rel_blk <= `ATB_OFS_TRIM3);
    wire logic        hit_nbk  = (rel_nbk >= `ATB_OFS_TRIM0)
                               & (rel_nbk <= `ATB_OFS_TRIM3);
    wire logic [13:0] rel_sel  = hit_blk ? rel_blk : rel_nbk;
    wire logic [13:0] reg_ofs  = rel_sel - `ATB_OFS_TRIM0;
    wire logic        size_ok  = hsize != 3'h7;
    wire atb_ap_s     next_ap  = '{write:   hwrite,
                                   mapped:  (hit_blk | hit_nbk) & size_ok,
                                   reg_sel: reg_ofs[1:0]};

    atb_ap_s     ap;
    atb_dp_e     dp_state;
    logic [7:0]  trim_reg [4];
    logic [4:0]  sleep_store;
    logic        locked;
    atb_trim_s   trim_map;

    // ----------------------------------------------------------------
    // bus data phase: writes take no wait state, reads take one
    // ----------------------------------------------------------------
    wire logic [31:0] rd_word = ap.mapped ? {24'h000000, trim_reg[ap.reg_sel]}
                                          : 32'h00000000;
    wire logic        wr_go   = (dp_state == DP_WRITE) & ap.mapped;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ap <= '0;
        end else if (ap_take) begin
            ap <= next_ap;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dp_state  <= DP_IDLE;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
        end else begin
            hresp <= 1'b0;
            unique case (dp_state)
                DP_IDLE, DP_WRITE: begin
                    if (ap_take) begin
                        dp_state  <= hwrite ? DP_WRITE : DP_READ;
                        hreadyout <= hwrite;
                    end else begin
                        dp_state <= DP_IDLE;
                    end
                end
                DP_READ: begin
                    hrdata    <= rd_word;
                    hreadyout <= 1'b1;
                    dp_state  <= DP_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // trim registers; reset only by rst, except register 2 while locked; never by low-power entry
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_reg
            localparam logic [7:0] WMASK = (i == 2) ? `ATB_WMASK_TRIM2
                                                    : `ATB_WMASK_FULL;
            wire logic frozen = (i == 2) & locked;
            wire logic wr_en  = wr_go & (ap.reg_sel == 2'(i)) & ~frozen;
            always_ff @(posedge sys_clk) begin
                if (rst & ~frozen) begin
                    trim_reg[i] <= `ATB_TRIM_RST;
                end else if (wr_en) begin
                    trim_reg[i] <= hwdata[7:0] & WMASK;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // analog side
    // ----------------------------------------------------------------
    atb_sleep_store u_sleep (
        .sys_clk    (sys_clk),
        .pwr_on_rst (pwr_on_rst),
        .din        (trim_reg[2][4:0]),
        .store      (sleep_store),
        .locked     (locked)
    );

    atb_trim_map u_map (
        .reg_zero    (trim_reg[0]),
        .reg_one     (trim_reg[1]),
        .reg_three   (trim_reg[3]),
        .sleep_store (sleep_store),
        .trim        (trim_map)
    );

    always_ff @(posedge sys_clk) begin
        if (pwr_on_rst) begin
            trim_out        <= '0;
            sleep_bg_locked <= 1'b0;
        end else begin
            trim_out        <= trim_map;
            sleep_bg_locked <= locked;
        end
    end

endmodule

// ==== atb_regs.svh ====
// register offsets, field positions and reset values of the trim bank
`ifndef ATB_REGS_SVH
`define ATB_REGS_SVH

// ----------------------------------------------------------------
// address map (word indices, byte address = 4 * index)
// ----------------------------------------------------------------
`define ATB_BASE_BLOCK   14'h0200
`define ATB_BASE_NONBLK  14'h0300
`define ATB_OFS_TRIM0    14'h00F0
`define ATB_OFS_TRIM1    14'h00F1
`define ATB_OFS_TRIM2    14'h00F2
`define ATB_OFS_TRIM3    14'h00F3

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define ATB_TRIM_RST     8'h00
`define ATB_WMASK_FULL   8'hFF
`define ATB_WMASK_TRIM2  8'h1F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ATB_T0_SLOPE_EN  7
`define ATB_T0_SLOPE     6
`define ATB_T0_WDOG_EN   5
`define ATB_T1_BG_EN     7
`define ATB_T1_BG_UP     5
`define ATB_T1_BG_DN     4
`define ATB_T1_IREF_EN   3
`define ATB_T2_SLP_EN    4
`define ATB_T2_SLP_LOCK  3
`define ATB_T3_OFS_EN    7

// ----------------------------------------------------------------
// trim codes
// ----------------------------------------------------------------
`define ATB_CODE_NEUTRAL 3'h0
`define ATB_WDOG_UNDEF   3'h6

`endif

// ==== atb_pkg.sv ====
// types shared by the analog trim register bank
package atb_pkg;

    // ----------------------------------------------------------------
    // data phase states of the bus slave
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DP_IDLE,
        DP_WRITE,
        DP_READ
    } atb_dp_e;

    // ----------------------------------------------------------------
    // captured address phase
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       write;
        logic       mapped;
        logic [1:0] reg_sel;
    } atb_ap_s;

    // ----------------------------------------------------------------
    // trim codes applied to the analog circuitry
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       xcvr_slope_trim;
        logic [2:0] wdog_clk_trim;
        logic       bandgap_slope_up;
        logic       bandgap_slope_down;
        logic [2:0] curref_trim;
        logic [2:0] sleep_bg_trim;
        logic [2:0] adc_offset_trim;
    } atb_trim_s;

endpackage

// ==== atb_sleep_store.sv ====
// analog storage of the sleep bandgap trim with its lock
`include "atb_regs.svh"

module atb_sleep_store
    import atb_pkg::*;
(
    // clock and power-up reset
    input  wire logic       sys_clk,
    input  wire logic       pwr_on_rst,
    // digital register contents
    input  wire logic [4:0] din,
    // analog storage
    output logic      [4:0] store,
    output logic            locked
);

    // ----------------------------------------------------------------
    // lock takes effect only with the enable bit set
    // ----------------------------------------------------------------
    assign locked = store[`ATB_T2_SLP_EN] & store[`ATB_T2_SLP_LOCK];

    // ----------------------------------------------------------------
    // storage follows the register until locked; only power-up clears
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (pwr_on_rst) begin
            store <= 5'h00;
        end else if (!locked) begin
            store <= din;
        end
    end

endmodule

// ==== atb_trim_map.sv ====
// maps stored trim bytes onto the codes applied to the analog side
`include "atb_regs.svh"

module atb_trim_map
    import atb_pkg::*;
(
    // stored registers
    input  wire logic [7:0] reg_zero,
    input  wire logic [7:0] reg_one,
    input  wire logic [7:0] reg_three,
    input  wire logic [4:0] sleep_store,
    // applied codes
    output atb_trim_s       trim
);

    // ----------------------------------------------------------------
    // per-field gating by enable bits
    // ----------------------------------------------------------------
    wire logic       slope_en = reg_zero[`ATB_T0_SLOPE_EN];
    wire logic       wdog_en  = reg_zero[`ATB_T0_WDOG_EN];
    wire logic       bg_en    = reg_one[`ATB_T1_BG_EN];
    wire logic       iref_en  = reg_one[`ATB_T1_IREF_EN];
    wire logic       slp_en   = sleep_store[`ATB_T2_SLP_EN];
    wire logic       ofs_en   = reg_three[`ATB_T3_OFS_EN];
    // undefined watchdog code falls back to the neutral code
    wire logic       wdog_ok  = reg_zero[2:0] != `ATB_WDOG_UNDEF;

    assign trim.xcvr_slope_trim    = slope_en & reg_zero[`ATB_T0_SLOPE];
    assign trim.wdog_clk_trim      = (wdog_en & wdog_ok) ? reg_zero[2:0]
                                   : `ATB_CODE_NEUTRAL;
    assign trim.bandgap_slope_up   = bg_en & reg_one[`ATB_T1_BG_UP];
    assign trim.bandgap_slope_down = bg_en & reg_one[`ATB_T1_BG_DN];
    assign trim.curref_trim        = iref_en ? reg_one[2:0]
                                   : `ATB_CODE_NEUTRAL;
    assign trim.sleep_bg_trim      = slp_en ? sleep_store[2:0]
                                   : `ATB_CODE_NEUTRAL;
    assign trim.adc_offset_trim    = ofs_en ? reg_three[6:4]
                                   : `ATB_CODE_NEUTRAL;

endmodule

// ==== atb_trim_bank_checker.sv ====
// assertions on the ports of the analog trim register bank
module atb_checker
    import atb_pkg::*;
(
    // clock and resets
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        pwr_on_rst,
    // bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // trim
    input wire atb_trim_s   trim_out,
    input wire logic        sleep_bg_locked
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence taken;
        hsel && htrans[1] && hready;
    endsequence
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    chk_read_wait: assert property (taken ##0 !hwrite |=> one_wait)
        else $error("read not answered after one wait");
    chk_write_nowait: assert property (taken ##0 hwrite |=> hreadyout)
        else $error("write stalled the bus");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    chk_rdata_byte: assert property (hrdata[31:8] == 24'h0)
        else $error("read data above bit 7 set");
    chk_wdog_undef: assert property (trim_out.wdog_clk_trim != 3'h6)
        else $error("undefined watchdog code applied");
    chk_lock_sticky: assert property (disable iff (pwr_on_rst)
        sleep_bg_locked |=> sleep_bg_locked)
        else $error("sleep lock dropped without power cycle");
    chk_sleep_frozen: assert property (disable iff (pwr_on_rst)
        sleep_bg_locked [*2] |=> $stable(trim_out.sleep_bg_trim))
        else $error("locked sleep trim changed");
    chk_rst_clears: assert property (disable iff (pwr_on_rst)
        rst [*2] |=> {trim_out[14:6], trim_out[2:0]} == 12'h000)
        else $error("trim outputs not cleared by reset");
endmodule

bind atb_trim_bank atb_checker atb_checker_inst (
    .sys_clk(sys_clk), .rst(rst), .pwr_on_rst(pwr_on_rst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .trim_out(trim_out), .sleep_bg_locked(sleep_bg_locked)
);

// ==== testbench.sv ====
// self-checking testbench of the analog trim register bank
module testbench import atb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        pwr_on_rst = 1'b1;
    logic        hsel = 1'b0;
    logic [15:0] haddr = 16'h0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    atb_trim_s   trim_out;
    logic        sleep_bg_locked;
    int          num_errors = 0;
    int          comparisons = 0;
    // byte address = 4 * (base + offset)
    localparam logic [15:0] BLK = 16'h0BC0;
    localparam logic [15:0] NBK = 16'h0FC0;
    assign hready = hreadyout;
    atb_trim_bank atb_trim_bank_inst (.sys_clk(sys_clk), .rst(rst),
        .pwr_on_rst(pwr_on_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .trim_out(trim_out),
        .sleep_bg_locked(sleep_bg_locked));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_ready();
        @(posedge sys_clk);
        while (hready !== 1'b1) begin
            @(posedge sys_clk);
        end
    endtask
    task automatic xfer(input logic [15:0] a, input logic w,
                        input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready();
    endtask
    task automatic expect_rd(input logic [15:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00);
        check(hrdata, {24'h0, e});
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic expect_trim(input atb_trim_s e);
        repeat (4) @(posedge sys_clk);
        check({17'h0, trim_out}, {17'h0, e});
    endtask
    task automatic expect_sleep(input logic [2:0] c, input logic lk);
        repeat (4) @(posedge sys_clk);
        check({29'h0, trim_out.sleep_bg_trim}, {29'h0, c});
        check({31'h0, sleep_bg_locked}, {31'h0, lk});
    endtask
    task automatic pulse_reset(input logic pwr);
        rst <= 1'b1;
        pwr_on_rst <= pwr;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        pwr_on_rst <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic test_reset();
        for (int i = 0; i < 4; i++) expect_rd(BLK + 16'(4 * i), 8'h00);
        expect_trim('0);
        $display("test_reset done");
    endtask
    task automatic test_access();
        logic [7:0] wv[4] = '{8'hFF, 8'hFF, 8'hE7, 8'hFF};
        logic [7:0] ev[4] = '{8'hFF, 8'hFF, 8'h07, 8'hFF};
        for (int i = 0; i < 4; i++) begin
            xfer(NBK + 16'(4 * i), 1'b1, wv[i]);
        end
        for (int i = 0; i < 4; i++) begin
            expect_rd(BLK + 16'(4 * i), ev[i]);
        end
        xfer(16'h0BD0, 1'b1, 8'h55);
        expect_rd(16'h0BD0, 8'h00);
        hsize <= 3'h7;
        xfer(NBK, 1'b1, 8'h00);
        hsize <= 3'h2;
        expect_rd(NBK, 8'hFF);
        expect_trim({1'b1, 3'h7, 1'b1, 1'b1, 3'h7, 3'h0, 3'h7});
        $display("test_access done");
    endtask
    task automatic test_gating();
        logic [7:0]  r0[3] = '{8'h45, 8'hA1, 8'hE6};
        logic [7:0]  r1[3] = '{8'h74, 8'h9C, 8'hAF};
        logic [7:0]  r3[3] = '{8'h70, 8'hC0, 8'hF8};
        atb_trim_s   ex[3] = '{15'h0,
            {1'b0, 3'h1, 1'b0, 1'b1, 3'h4, 3'h0, 3'h4},
            {1'b1, 3'h0, 1'b1, 1'b0, 3'h7, 3'h0, 3'h7}};
        for (int i = 0; i < 3; i++) begin
            xfer(BLK, 1'b1, r0[i]);
            xfer(BLK + 16'h4, 1'b1, r1[i]);
            xfer(BLK + 16'hC, 1'b1, r3[i]);
            expect_trim(ex[i]);
        end
        $display("test_gating done");
    endtask
    task automatic test_lock();
        xfer(BLK + 16'h8, 1'b1, 8'h16);
        expect_sleep(3'h6, 1'b0);
        xfer(BLK + 16'h8, 1'b1, 8'h0E);
        expect_sleep(3'h0, 1'b0);
        xfer(BLK + 16'h8, 1'b1, 8'h1D);
        expect_sleep(3'h5, 1'b1);
        xfer(BLK + 16'h8, 1'b1, 8'h13);
        expect_rd(BLK + 16'h8, 8'h1D);
        pulse_reset(1'b0);
        expect_rd(BLK, 8'h00);
        expect_rd(BLK + 16'h8, 8'h1D);
        expect_sleep(3'h5, 1'b1);
        pulse_reset(1'b1);
        expect_rd(BLK + 16'h8, 8'h00);
        expect_sleep(3'h0, 1'b0);
        $display("test_lock done");
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100us;
        num_errors++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        pwr_on_rst <= 1'b0;
        @(posedge sys_clk);
        test_reset();
        test_access();
        test_gating();
        test_lock();
        print_verdict();
    end
endmodule
